// [dsc_pkg.sv]
// Package for the drive serial command front end: register map, field layout, reset values, codes.
// Assumes a 32-bit Avalon-MM slave port with waitrequest and a single clock.
package dsc_pkg;

   // ==========================================================================
   // Register offsets (byte addresses)
   // ==========================================================================
   localparam logic [5:0] DSC_OFS_REF       = 6'h00;
   localparam logic [5:0] DSC_OFS_CTRLWORD  = 6'h04;
   localparam logic [5:0] DSC_OFS_SELECT    = 6'h08;
   localparam logic [5:0] DSC_OFS_REF_LIMIT = 6'h0C;
   localparam logic [5:0] DSC_OFS_FRQ_LIMIT = 6'h10;
   localparam logic [5:0] DSC_OFS_FREQ_IN   = 6'h14;
   localparam logic [5:0] DSC_OFS_FREQ_OUT  = 6'h18;
   localparam logic [5:0] DSC_OFS_SPEED     = 6'h1C;
   localparam logic [5:0] DSC_OFS_STATION   = 6'h20;
   localparam logic [5:0] DSC_OFS_CMD       = 6'h24;

   // ==========================================================================
   // Scaling and field positions
   // ==========================================================================
   localparam int          DSC_WORD_W      = 16;
   localparam int          DSC_FULL_SHIFT  = 14;
   localparam logic [15:0] DSC_FULL_SCALE  = 16'h4000;
   localparam logic [15:0] DSC_MAX_SCALE   = 16'h7FFF;
   localparam int          DSC_CW_DCHOLD   = 2;
   localparam int          DSC_CW_COAST    = 3;
   localparam int          DSC_CW_QSTOP    = 4;
   localparam int          DSC_SEL_COAST   = 0;
   localparam int          DSC_SEL_QSTOP   = 2;
   localparam int          DSC_SEL_DCHOLD  = 4;
   localparam int          DSC_NUM_MERGE   = 3;

   // ==========================================================================
   // Station address and baud rate
   // ==========================================================================
   localparam logic [7:0]  DSC_ADDR_DEFAULT   = 8'h01;
   localparam logic [7:0]  DSC_ADDR_MAX_NAT   = 8'hF7;
   localparam logic [7:0]  DSC_ADDR_MAX_BLD   = 8'hFF;
   localparam logic [7:0]  DSC_ADDR_MAX_RTU   = 8'hF7;
   localparam logic [2:0]  DSC_BAUD_DEFAULT   = 3'h5;
   localparam logic [2:0]  DSC_BAUD_MAX_CODE  = 3'h5;
   localparam logic [31:0] DSC_RD_UNMAPPED    = 32'h0000_0000;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [1:0] {
      DSC_SRC_DIGITAL = 2'h0,
      DSC_SRC_SERIAL  = 2'h1,
      DSC_SRC_AND     = 2'h2,
      DSC_SRC_OR      = 2'h3
   } dsc_src_type;

   typedef enum logic [1:0] {
      DSC_PROTO_NATIVE = 2'h0,
      DSC_PROTO_BLDG   = 2'h1,
      DSC_PROTO_RTU    = 2'h3
   } dsc_proto_type;

   localparam logic [5:0]  DSC_SELECT_RESET = {DSC_SRC_OR, DSC_SRC_OR, DSC_SRC_OR};

   typedef struct packed {
      logic [5:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } dsc_avm_req_type;

   typedef struct packed {
      logic        coast_n;
      logic        qstop_n;
      logic        dchold_n;
   } dsc_cmd_type;

   typedef struct packed {
      logic        coast_n;
      logic        qstop_n;
      logic        dchold_n;
      logic        reverse;
   } dsc_drive_type;

endpackage : dsc_pkg

// [dsc_merge.sv]
// Command source merge: combines one digital-input level with one control-word bit.
// Both sources active low; selector code from the main block.
`timescale 1ns/100ps
module dsc_merge
   import dsc_pkg::*;
(
   // Sources
   input  wire logic        dig_n,
   input  wire logic        ser_n,
   input  wire dsc_src_type sel,
   // Result, active low
   output      logic        cmd_n
);

   // Run needs: 0 dig high, 1 ser high, 2 either high, 3 both high
   wire logic run_dig = dig_n;
   wire logic run_ser = ser_n;
   wire logic run_and = dig_n | ser_n;
   wire logic run_or  = dig_n & ser_n;

   assign cmd_n = (sel == DSC_SRC_DIGITAL) ? run_dig :
                  (sel == DSC_SRC_SERIAL)  ? run_ser :
                  (sel == DSC_SRC_AND)     ? run_and : run_or;

endmodule : dsc_merge

// [dsc_core.sv]
// Drive serial command front end: reference decode, frequency encode, address/baud hold, command merge.
// Assumes an Avalon-MM master on the register port and a local operator unit on its own write strobes.
//
// How it works
// - Speed reference is signed 16-bit; 16384 is 100%, 32767 is 200%.
// - Positive reference 0..16384 maps linearly between minimum and maximum reference.
// - Negative two's complement reference reverses rotation direction.
// - Output frequency reported signed 16-bit, 16384 is 100%.
// - Reported 0..16384 scales between frequency low and high limits.
// - Station address range depends on protocol; default 1.
// - Station address writes over the serial bus are refused; local unit only.
// - Baud codes 0..5 mean 300..9600 baud; default 9600.
// - Baud code cannot change over the serial bus; local unit only.
// - Selector codes: digital, serial, AND, OR; OR is default.
// - Serial code ignores the digital input entirely.
// - Coast active low on input and control-word bit 3, merged per code.
// - Under AND code both sources must activate before command takes effect.
// - Quick-stop active low on input and bit 4, same tables.
// - DC hold active low on input and bit 2, per its own selector.
`timescale 1ns/100ps
module dsc_core
   import dsc_pkg::*;
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // Avalon-MM slave
   input  wire logic [5:0]    avs_address,
   input  wire logic          avs_read,
   input  wire logic          avs_write,
   input  wire logic [31:0]   avs_writedata,
   input  wire logic [3:0]    avs_byteenable,
   output      logic [31:0]   avs_readdata,
   output      logic          avs_waitrequest,
   // Local operator unit
   input  wire logic          op_addr_we,
   input  wire logic [7:0]    op_addr,
   input  wire logic          op_baud_we,
   input  wire logic [2:0]    op_baud,
   input  wire dsc_proto_type op_proto,
   // Digital inputs, active low
   input  wire logic          coast_in_n,
   input  wire logic          qstop_in_n,
   input  wire logic          dchold_in_n,
   // Drive side
   output      dsc_drive_type drive,
   output      logic [15:0]   speed_ref,
   output      logic [7:0]    station_addr,
   output      logic [2:0]    baud_code
);

   // ==========================================================================
   // Bus front end: one wait cycle, answer on the second edge
   // ==========================================================================
   dsc_avm_req_type req;
   logic            ack_r;
   logic            ack_nxt;
   logic [15:0]     ref_r;
   logic [15:0]     cw_r;
   logic [5:0]      sel_r;
   logic [15:0]     ref_min_r;
   logic [15:0]     ref_max_r;
   logic [15:0]     frq_lo_r;
   logic [15:0]     frq_hi_r;
   logic [15:0]     freq_in_r;
   assign req.address    = avs_address;
   assign req.read       = avs_read;
   assign req.write      = avs_write;
   assign req.writedata  = avs_writedata;
   assign req.byteenable = avs_byteenable;

   wire logic req_on = req.read | req.write;
   assign ack_nxt         = req_on & ~ack_r;
   assign avs_waitrequest = req_on & ~ack_r;
   wire logic wr_go = req.write & ack_r;

   // Ack alternates so a held request is answered once every two edges
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
      end
   end

   // Byte-lane merge of write data into a 32-bit old value
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   wire logic [31:0] wd_m_ref  = lane_merge({16'h0000, ref_r}, req.writedata, req.byteenable);
   wire logic [31:0] wd_m_cw   = lane_merge({16'h0000, cw_r}, req.writedata, req.byteenable);
   wire logic [31:0] wd_m_sel  = lane_merge({26'h000_0000, sel_r}, req.writedata, req.byteenable);
   wire logic [31:0] wd_m_rlim = lane_merge({ref_max_r, ref_min_r}, req.writedata, req.byteenable);
   wire logic [31:0] wd_m_flim = lane_merge({frq_hi_r, frq_lo_r}, req.writedata, req.byteenable);
   wire logic [31:0] wd_m_fin  = lane_merge({16'h0000, freq_in_r}, req.writedata, req.byteenable);

   // Address decode shared by write strobes and read mux
   wire logic at_ref  = (req.address == DSC_OFS_REF);
   wire logic at_cw   = (req.address == DSC_OFS_CTRLWORD);
   wire logic at_sel  = (req.address == DSC_OFS_SELECT);
   wire logic at_rlim = (req.address == DSC_OFS_REF_LIMIT);
   wire logic at_flim = (req.address == DSC_OFS_FRQ_LIMIT);
   wire logic at_fin  = (req.address == DSC_OFS_FREQ_IN);
   wire logic at_fout = (req.address == DSC_OFS_FREQ_OUT);
   wire logic at_spd  = (req.address == DSC_OFS_SPEED);
   wire logic at_stn  = (req.address == DSC_OFS_STATION);
   wire logic at_cmd  = (req.address == DSC_OFS_CMD);

   wire logic hit_ref  = wr_go & at_ref;
   wire logic hit_cw   = wr_go & at_cw;
   wire logic hit_sel  = wr_go & at_sel;
   wire logic hit_rlim = wr_go & at_rlim;
   wire logic hit_flim = wr_go & at_flim;
   wire logic hit_fin  = wr_go & at_fin;

   // ==========================================================================
   // Software registers
   // ==========================================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_r     <= 16'h0000;
         cw_r      <= 16'hFFFF;
         sel_r     <= DSC_SELECT_RESET;
         freq_in_r <= 16'h0000;
      end else begin
         if (hit_ref)  ref_r <= wd_m_ref[15:0];
         if (hit_cw)   cw_r  <= wd_m_cw[15:0];
         if (hit_sel)  sel_r <= wd_m_sel[5:0];
         if (hit_fin)  freq_in_r <= wd_m_fin[15:0];
      end
   end

   // Both halves of a limit word land together
   always_ff @(posedge clk) begin
      if (rst) begin
         ref_min_r <= 16'h0000;
         ref_max_r <= 16'h0000;
      end else if (hit_rlim) begin
         ref_min_r <= wd_m_rlim[15:0];
         ref_max_r <= wd_m_rlim[31:16];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         frq_lo_r <= 16'h0000;
         frq_hi_r <= 16'h0000;
      end else if (hit_flim) begin
         frq_lo_r <= wd_m_flim[15:0];
         frq_hi_r <= wd_m_flim[31:16];
      end
   end

   // ==========================================================================
   // Station address and baud, local unit only
   // ==========================================================================
   logic [7:0] addr_r;
   logic [2:0] baud_r;

   wire logic [7:0] addr_lo  = (op_proto == DSC_PROTO_NATIVE) ? 8'h00 : 8'h01;
   wire logic [7:0] addr_hi  = (op_proto == DSC_PROTO_BLDG)   ? DSC_ADDR_MAX_BLD :
                               (op_proto == DSC_PROTO_RTU)    ? DSC_ADDR_MAX_RTU : DSC_ADDR_MAX_NAT;
   wire logic       addr_ok  = (op_addr >= addr_lo) && (op_addr <= addr_hi);
   wire logic       baud_ok  = op_baud <= DSC_BAUD_MAX_CODE;

   // Bus has no write path here, so serial writes to these never land
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_r <= DSC_ADDR_DEFAULT;
      end else if (op_addr_we && addr_ok) begin
         addr_r <= op_addr;
      end
   end

   // Out-of-range codes from the local unit are dropped
   always_ff @(posedge clk) begin
      if (rst) begin
         baud_r <= DSC_BAUD_DEFAULT;
      end else if (op_baud_we && baud_ok) begin
         baud_r <= op_baud;
      end
   end
   assign station_addr = addr_r;
   assign baud_code    = baud_r;

   // ==========================================================================
   // Reference decode
   // ==========================================================================
   logic [15:0] speed_r;
   logic        rev_r;

   wire logic        ref_neg = ref_r[15];
   wire logic [15:0] ref_mag = ref_neg ? (~ref_r + 16'h0001) : ref_r;
   wire logic [16:0] ref_span = {1'b0, ref_max_r} - {1'b0, ref_min_r};
   // Magnitude of 0x8000 is 32768; the wide product still holds it
   wire logic [33:0] ref_prod = {17'h0_0000, ref_mag} * {17'h0_0000, ref_span};
   wire logic [15:0] ref_scl  = ref_prod[DSC_FULL_SHIFT +: 16];
   wire logic [15:0] speed_nxt = ref_min_r + ref_scl;

   always_ff @(posedge clk) begin
      if (rst) begin
         speed_r <= 16'h0000;
         rev_r   <= 1'b0;
      end else begin
         speed_r <= speed_nxt;
         rev_r   <= ref_neg;
      end
   end
   assign speed_ref = speed_r;

   // ==========================================================================
   // Frequency encode
   // ==========================================================================
   logic [15:0] freq_out_r;

   wire logic [15:0] frq_span = frq_hi_r - frq_lo_r;
   // Zero span reports 0 rather than dividing by zero
   wire logic        frq_zero = (frq_span == 16'h0000);
   // Below the low limit the offset is negated, so the code goes negative
   wire logic        frq_low  = freq_in_r < frq_lo_r;
   wire logic [15:0] frq_off  = frq_low ? (frq_lo_r - freq_in_r) : (freq_in_r - frq_lo_r);
   wire logic [31:0] frq_num  = {2'b00, frq_off, 14'h0000};
   wire logic [31:0] frq_q    = frq_zero ? 32'h0000_0000 : frq_num / {16'h0000, frq_span};
   wire logic [15:0] frq_sat  = (frq_q > {16'h0000, DSC_MAX_SCALE}) ? DSC_MAX_SCALE : frq_q[15:0];
   wire logic [15:0] frq_enc  = frq_low ? (~frq_sat + 16'h0001) : frq_sat;

   always_ff @(posedge clk) begin
      if (rst) begin
         freq_out_r <= 16'h0000;
      end else begin
         freq_out_r <= frq_enc;
      end
   end

   // ==========================================================================
   // Command merges
   // ==========================================================================
   dsc_cmd_type dig_n;
   dsc_cmd_type ser_n;
   dsc_cmd_type mrg_n;
   dsc_cmd_type cmd_r;

   assign dig_n = '{coast_n: coast_in_n, qstop_n: qstop_in_n, dchold_n: dchold_in_n};
   assign ser_n = '{coast_n:  cw_r[DSC_CW_COAST],
                    qstop_n:  cw_r[DSC_CW_QSTOP],
                    dchold_n: cw_r[DSC_CW_DCHOLD]};

   // Struct order is coast, qstop, dchold: bit 2 down to 0; selector fields 0,2,4
   for (genvar g = 0; g < DSC_NUM_MERGE; g++) begin : g_merge
      dsc_merge u_merge (
         .dig_n (dig_n[DSC_NUM_MERGE-1-g]),
         .ser_n (ser_n[DSC_NUM_MERGE-1-g]),
         .sel   (dsc_src_type'(sel_r[2*g +: 2])),
         .cmd_n (mrg_n[DSC_NUM_MERGE-1-g])
      );
   end

   // Registered so a selector write or input change shows on one edge
   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_r <= '{coast_n: 1'b1, qstop_n: 1'b1, dchold_n: 1'b1};
      end else begin
         cmd_r <= mrg_n;
      end
   end
   assign drive = '{coast_n: cmd_r.coast_n, qstop_n: cmd_r.qstop_n,
                    dchold_n: cmd_r.dchold_n, reverse: rev_r};

   // ==========================================================================
   // Read mux
   // ==========================================================================
   logic [31:0] rd_r;
   // Unmapped offsets read as zero
   wire logic [31:0] rd_sel =
      at_ref  ? {16'h0000, ref_r} :
      at_cw   ? {16'h0000, cw_r} :
      at_sel  ? {26'h000_0000, sel_r} :
      at_rlim ? {ref_max_r, ref_min_r} :
      at_flim ? {frq_hi_r, frq_lo_r} :
      at_fin  ? {16'h0000, freq_in_r} :
      at_fout ? {16'h0000, freq_out_r} :
      at_spd  ? {15'h0000, rev_r, speed_r} :
      at_stn  ? {21'h00_0000, baud_r, addr_r} :
      at_cmd  ? {28'h000_0000, drive} : DSC_RD_UNMAPPED;

   // Read data captured in the wait cycle, held until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_r <= 32'h0000_0000;
      end else if (req.read & ~ack_r) begin
         rd_r <= rd_sel;
      end
   end
   assign avs_readdata = rd_r;

endmodule : dsc_core

// [dsc_core_monitor.sv]
// Port checker for dsc_core.
// Bound from tb; one clock, synchronous active-high reset.
`timescale 1ns/100ps
module dsc_core_monitor
   import dsc_pkg::*;
(
   // Clock and reset
   input wire logic          clk,
   input wire logic          rst,
   // Register bus
   input wire logic [5:0]    avs_address,
   input wire logic          avs_read,
   input wire logic          avs_write,
   input wire logic [31:0]   avs_readdata,
   input wire logic          avs_waitrequest,
   // Local unit
   input wire logic          op_addr_we,
   input wire logic [7:0]    op_addr,
   input wire logic          op_baud_we,
   input wire logic [2:0]    op_baud,
   // Drive side
   input wire dsc_drive_type drive,
   input wire logic [15:0]   speed_ref,
   input wire logic [7:0]    station_addr,
   input wire logic [2:0]    baud_code
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================================================
   // Bus timing
   // ==========================================================================
   one_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("request without exactly one wait cycle");
   idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
      else $error("waitrequest high while idle");
   unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h3C |->
      avs_readdata == DSC_RD_UNMAPPED) else $error("unmapped read not zero");
   // ==========================================================================
   // Outputs
   // ==========================================================================
   reset_vals_a: assert property ($fell(rst) |-> drive == 4'hE && speed_ref == 16'h0000 &&
      station_addr == DSC_ADDR_DEFAULT && baud_code == DSC_BAUD_DEFAULT) else $error("bad reset value");
   addr_local_a: assert property (!$stable(station_addr) |-> $past(op_addr_we))
      else $error("station address changed without local write");
   addr_take_a: assert property (op_addr_we && op_addr != 8'h00 && op_addr <= DSC_ADDR_MAX_RTU |=>
      station_addr == $past(op_addr)) else $error("valid station address not taken");
   baud_local_a: assert property (!$stable(baud_code) |-> $past(op_baud_we))
      else $error("baud code changed without local write");
   baud_take_a: assert property (op_baud_we && op_baud <= DSC_BAUD_MAX_CODE |=> baud_code == $past(op_baud))
      else $error("valid baud code not taken");
   baud_refuse_a: assert property (op_baud_we && op_baud > DSC_BAUD_MAX_CODE |=> $stable(baud_code))
      else $error("bad baud code taken");
   speed_src_a: assert property (!$stable(speed_ref) |-> $past(avs_write) || $past(avs_write, 2))
      else $error("speed reference changed without bus write");
endmodule : dsc_core_monitor

// [dsc_bus_master.sv]
// Avalon-MM master model standing for the serial bus master.
// Drives after rising edges; waits on waitrequest with no limit of its own.
`timescale 1ns/100ps
module dsc_bus_master (
   // Clock
   input  wire logic        clk,
   // Avalon-MM master
   output      logic [5:0]  avs_address,
   output      logic        avs_read,
   output      logic        avs_write,
   output      logic [31:0] avs_writedata,
   output      logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_readdata,
   input  wire logic        avs_waitrequest
);
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'h0;
   end
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
                       output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !w;
      avs_write <= w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Released bus shows no stale value
      avs_address <= ~a;
      avs_writedata <= ~d;
      avs_byteenable <= 4'h0;
   endtask : xfer
endmodule : dsc_bus_master

// [tb.sv]
// Self-checking bench for dsc_core.
// Master model drives the bus; bench drives local unit and digital inputs.
`timescale 1ns/100ps
module tb;
   import dsc_pkg::*;
   logic          clk, rst, avs_read, avs_write, avs_waitrequest, op_addr_we, op_baud_we;
   logic [5:0]    avs_address;
   logic [31:0]   avs_writedata, avs_readdata, rdat;
   logic [3:0]    avs_byteenable;
   logic [7:0]    op_addr, station_addr;
   logic [2:0]    op_baud, baud_code;
   dsc_proto_type op_proto;
   logic          coast_in_n, qstop_in_n, dchold_in_n;
   dsc_drive_type drive;
   logic [15:0]   speed_ref, m;
   logic [1:0]    c;
   int            n_mismatch, num_checks;
   // Rows: {code, digital, serial, expected level}
   localparam logic [4:0] ROWS [16] = '{5'h00, 5'h02, 5'h05, 5'h07, 5'h08, 5'h0B, 5'h0C, 5'h0F,
      5'h10, 5'h13, 5'h15, 5'h17, 5'h18, 5'h1A, 5'h1C, 5'h1F};
   // Rows: {negative, magnitude, speed}
   localparam logic [32:0] REFS [6] = '{{1'b0, 16'h2000, 16'h0258}, {1'b0, 16'h4000, 16'h044C},
      {1'b0, 16'h0000, 16'h0064}, {1'b1, 16'h2000, 16'h0258}, {1'b0, 16'h7FFF, 16'h0833},
      {1'b1, 16'h4000, 16'h044C}};
   // Rows: {low, high, present, encoded}
   localparam logic [63:0] FRQ [8] = '{64'h0000_0032_0019_2000, 64'h0000_0032_0032_4000,
      64'h0000_0032_0000_0000, 64'h0000_0032_0064_7FFF, 64'h000A_003C_0023_2000, 64'h000A_003C_000A_0000,
      64'h000A_003C_0000_F334, 64'h0032_0032_0040_0000};
   // Rows: {protocol, value, expected address}
   localparam logic [17:0] ST [7] = '{18'h0_0000, 18'h3_0000, 18'h3_F7F7, 18'h3_F8F7, 18'h1_FFFF,
      18'h0_F8FF, 18'h1_00FF};
   dsc_bus_master u_mst (.clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   dsc_core uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .op_addr_we(op_addr_we), .op_addr(op_addr), .op_baud_we(op_baud_we),
      .op_baud(op_baud), .op_proto(op_proto), .coast_in_n(coast_in_n), .qstop_in_n(qstop_in_n),
      .dchold_in_n(dchold_in_n), .drive(drive), .speed_ref(speed_ref), .station_addr(station_addr),
      .baud_code(baud_code));
   // ==========================================================================
   // Helpers
   // ==========================================================================
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      u_mst.xfer(1'b1, a, d, 4'hF, rdat);
   endtask : wr
   task automatic rd(input logic [5:0] a);
      u_mst.xfer(1'b0, a, 32'h0000_0000, 4'hF, rdat);
   endtask : rd
   task automatic op(input logic s, input logic [1:0] p, input logic [7:0] v);
      @(posedge clk);
      op_proto <= dsc_proto_type'(p);
      op_addr_we <= !s;
      op_baud_we <= s;
      op_addr <= v;
      op_baud <= v[2:0];
      @(posedge clk);
      op_addr_we <= 1'b0;
      op_baud_we <= 1'b0;
      @(negedge clk);
   endtask : op
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #40000;
      n_mismatch++;
      $display("unexpected watchdog: expected done seen hung");
      stop_test();
   end
   // ==========================================================================
   // Tests
   // ==========================================================================
   initial begin
      {rst, op_addr_we, op_baud_we, op_addr, op_baud} = {3'h4, 8'h00, 3'h0};
      op_proto = DSC_PROTO_NATIVE;
      {coast_in_n, qstop_in_n, dchold_in_n} = 3'h7;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (ROWS[i]) begin
         c = ROWS[i][4:3];
         wr(DSC_OFS_SELECT, {26'h0, c, c, c});
         wr(DSC_OFS_CTRLWORD, ROWS[i][1] ? 32'h0000_FFFF : 32'h0000_FFE3);
         @(posedge clk);
         {coast_in_n, qstop_in_n, dchold_in_n} <= {3{ROWS[i][2]}};
         @(posedge clk);
         @(negedge clk);
         chk("merged", {29'h0, {3{ROWS[i][0]}}}, {29'h0, drive[3:1]});
      end
      $display("merge test done");
      wr(DSC_OFS_REF_LIMIT, 32'h044C_0064);
      foreach (REFS[i]) begin
         m = REFS[i][31:16];
         wr(DSC_OFS_REF, {16'h0, REFS[i][32] ? ~m + 16'h0001 : m});
         repeat (2) @(negedge clk);
         chk("speed", {16'h0, REFS[i][15:0]}, {16'h0, speed_ref});
         chk("reverse", {31'h0, REFS[i][32]}, {31'h0, drive.reverse});
         rd(DSC_OFS_SPEED);
         chk("speed reg", {15'h0, REFS[i][32], REFS[i][15:0]}, rdat);
      end
      foreach (FRQ[i]) begin
         wr(DSC_OFS_FRQ_LIMIT, {FRQ[i][47:32], FRQ[i][63:48]});
         wr(DSC_OFS_FREQ_IN, {16'h0, FRQ[i][31:16]});
         rd(DSC_OFS_FREQ_OUT);
         chk("freq", {16'h0, FRQ[i][15:0]}, {16'h0, rdat[15:0]});
      end
      $display("scaling test done");
      foreach (ST[i]) begin
         op(1'b0, ST[i][17:16], ST[i][15:8]);
         chk("station", {24'h0, ST[i][7:0]}, {24'h0, station_addr});
      end
      for (int b = 0; b < 6; b++) begin
         op(1'b1, 2'h0, 8'(b));
         chk("baud", 32'(b), {29'h0, baud_code});
         if (b < 2) begin
            op(1'b1, 2'h0, 8'(b + 6));
            chk("baud refused", 32'(b), {29'h0, baud_code});
         end
      end
      wr(DSC_OFS_STATION, 32'h0000_0307);
      rd(DSC_OFS_STATION);
      chk("station reg", 32'h0000_05FF, rdat);
      u_mst.xfer(1'b1, DSC_OFS_CTRLWORD, 32'h0000_0000, 4'h2, rdat);
      rd(DSC_OFS_CTRLWORD);
      chk("lane write", 32'h0000_00FF, rdat);
      rd(6'h3C);
      chk("unmapped", DSC_RD_UNMAPPED, rdat);
      $display("station test done");
      @(posedge clk);
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("reset outputs", 32'h7000_000D, {1'h0, drive, speed_ref, station_addr, baud_code});
      rd(DSC_OFS_SELECT);
      chk("selectors", {26'h0, DSC_SELECT_RESET}, rdat);
      rd(DSC_OFS_CTRLWORD);
      chk("control word", 32'h0000_FFFF, rdat);
      $display("reset test done");
      stop_test();
   end
endmodule : tb
bind dsc_core dsc_core_monitor u_mon (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .op_addr_we(op_addr_we), .op_addr(op_addr), .op_baud_we(op_baud_we), .op_baud(op_baud), .drive(drive),
   .speed_ref(speed_ref), .station_addr(station_addr), .baud_code(baud_code));
